// ### pkg/ems_pkg.sv
// package for the eeprom margin search sequencer
// assumes one 125 MHz clock and a simple word-wide memory access port
package ems_pkg;
	// memory geometry
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam logic [5:0] LAST_ADDR = 6'h3f;
	// checkerboard word for address zero, bit 0 at the low end
	localparam logic [15:0] PATTERN_WORD0 = 16'haaaa;
	// search iterations per measurement
	localparam logic [3:0] ITER_COUNT = 4'h9;
	// margin voltage code: signed, full scale 5 V = 16'sd5000 millivolts
	localparam logic signed [15:0] LIMIT_ONES = 16'sh1388;
	localparam logic signed [15:0] LIMIT_ZEROS = -16'sh1388;
	localparam logic signed [15:0] LIMIT_ZERO = 16'sh0000;
	// settle time after applying the margin voltage
	localparam int SETTLE_US = 100;
	localparam int CLK_MHZ = 125;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_WRITE = 4'h1,
		ST_VERIFY = 4'h2,
		ST_ENABLE = 4'h3,
		ST_APPLY = 4'h4,
		ST_READ = 4'h5,
		ST_UPDATE = 4'h6,
		ST_OFF = 4'h7,
		ST_DONE = 4'h8
	} ems_state_t;
endpackage

// ### hw/ems_margin_search.sv
// eeprom margin search sequencer: writes checkerboard, verifies, binary-searches margin
// assumes a memory access port with req/ack handshake and synchronous inputs
`timescale 1ns/1ns
module ems_margin_search #(
	parameter int SETTLE_CYCLES = ems_pkg::SETTLE_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// user side
	input wire logic start,
	input wire logic selZeros,
	input wire logic invertPattern,
	output logic busy,
	output logic done,
	output logic patternError,
	output logic signed [15:0] marginCode,
	// memory access port
	output logic memReq,
	output logic memWrite,
	output logic [5:0] memAddr,
	output logic [15:0] memWdata,
	input wire logic memAck,
	input wire logic [15:0] memRdata,
	// margining pins
	output logic marginEnable,
	output logic marginEnableNeg,
	output logic marginVoltageOn,
	output logic signed [15:0] marginVoltage
);
	ems_pkg::ems_state_t state, next_state;
	logic [5:0] addr, next_addr;
	logic [15:0] word, next_word;
	logic signed [15:0] passLim, next_passLim, failLim, next_failLim;
	logic [3:0] iter, next_iter;
	logic mismatch, next_mismatch;
	logic zeros, next_zeros;
	logic [31:0] wait_cnt, next_wait_cnt;
	logic next_done, next_patternError;
	logic signed [15:0] next_marginCode, next_marginVoltage;
	logic signed [16:0] midSum;

	// midpoint of the current limits; 17 bits so the sum cannot wrap
	always_comb begin
		midSum = 17'(passLim) + 17'(failLim);
	end

	// next state computation
	always_comb begin
		next_state = state;
		next_addr = addr;
		next_word = word;
		next_passLim = passLim;
		next_failLim = failLim;
		next_iter = iter;
		next_mismatch = mismatch;
		next_zeros = zeros;
		next_wait_cnt = wait_cnt;
		next_done = done;
		next_patternError = patternError;
		next_marginCode = marginCode;
		next_marginVoltage = marginVoltage;
		case (state)
			ems_pkg::ST_IDLE, ems_pkg::ST_DONE: begin
				if (start) begin
					next_state = ems_pkg::ST_WRITE;
					next_done = 1'b0;
					next_patternError = 1'b0;
					next_zeros = selZeros;
					next_addr = '0;
					next_word = invertPattern ? ~ems_pkg::PATTERN_WORD0 : ems_pkg::PATTERN_WORD0;
					next_mismatch = 1'b0;
				end
			end
			ems_pkg::ST_WRITE: begin
				if (memAck) begin
					next_word = ~word;
					next_addr = addr + 6'h01;
					if (addr == ems_pkg::LAST_ADDR) begin
						next_state = ems_pkg::ST_VERIFY;
						next_word = invertPattern ? ~ems_pkg::PATTERN_WORD0 : ems_pkg::PATTERN_WORD0;
					end
				end
			end
			ems_pkg::ST_VERIFY: begin
				if (memAck) begin
					next_word = ~word;
					next_addr = addr + 6'h01;
					if (memRdata != word) begin
						next_mismatch = 1'b1;
					end
					if (addr == ems_pkg::LAST_ADDR) begin
						if (mismatch || memRdata != word) begin
							next_patternError = 1'b1;
							next_done = 1'b1;
							next_state = ems_pkg::ST_DONE;
						end else begin
							next_state = ems_pkg::ST_ENABLE;
							next_passLim = ems_pkg::LIMIT_ZERO;
							next_failLim = zeros ? ems_pkg::LIMIT_ZEROS : ems_pkg::LIMIT_ONES;
							next_iter = '0;
							next_wait_cnt = '0;
						end
					end
				end
			end
			ems_pkg::ST_ENABLE: begin
				// enable must settle before the voltage is applied
				next_wait_cnt = wait_cnt + 32'h1;
				if (wait_cnt == 32'(SETTLE_CYCLES - 1)) begin
					next_state = ems_pkg::ST_APPLY;
					next_marginVoltage = 16'(midSum >>> 1);
					next_wait_cnt = '0;
				end
			end
			ems_pkg::ST_APPLY: begin
				next_wait_cnt = wait_cnt + 32'h1;
				if (wait_cnt == 32'(SETTLE_CYCLES - 1)) begin
					next_state = ems_pkg::ST_READ;
					next_addr = '0;
					next_word = invertPattern ? ~ems_pkg::PATTERN_WORD0 : ems_pkg::PATTERN_WORD0;
					next_mismatch = 1'b0;
				end
			end
			ems_pkg::ST_READ: begin
				if (memAck) begin
					next_word = ~word;
					next_addr = addr + 6'h01;
					if (memRdata != word) begin
						next_mismatch = 1'b1;
					end
					if (addr == ems_pkg::LAST_ADDR) begin
						next_state = ems_pkg::ST_UPDATE;
					end
				end
			end
			ems_pkg::ST_UPDATE: begin
				if (mismatch) begin
					next_failLim = marginVoltage;
				end else begin
					next_passLim = marginVoltage;
				end
				next_iter = iter + 4'h1;
				next_wait_cnt = '0;
				if (iter == ems_pkg::ITER_COUNT - 4'h1) begin
					next_state = ems_pkg::ST_OFF;
				end else begin
					next_state = ems_pkg::ST_APPLY;
					next_marginVoltage = mismatch ?
						16'((17'(passLim) + 17'(marginVoltage)) >>> 1) :
						16'((17'(marginVoltage) + 17'(failLim)) >>> 1);
				end
			end
			ems_pkg::ST_OFF: begin
				next_marginCode = 16'(midSum >>> 1);
				next_done = 1'b1;
				next_state = ems_pkg::ST_DONE;
			end
			default: begin
				next_state = ems_pkg::ST_IDLE;
			end
		endcase
	end

	// state registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= ems_pkg::ST_IDLE;
			addr <= '0;
			word <= '0;
			passLim <= '0;
			failLim <= '0;
			iter <= '0;
			mismatch <= 1'b0;
			zeros <= 1'b0;
			wait_cnt <= '0;
			done <= 1'b0;
			patternError <= 1'b0;
			marginCode <= '0;
			marginVoltage <= '0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			word <= next_word;
			passLim <= next_passLim;
			failLim <= next_failLim;
			iter <= next_iter;
			mismatch <= next_mismatch;
			zeros <= next_zeros;
			wait_cnt <= next_wait_cnt;
			done <= next_done;
			patternError <= next_patternError;
			marginCode <= next_marginCode;
			marginVoltage <= next_marginVoltage;
		end
	end

	// memory port and margin pins; enable spans enable, apply, read, update
	always_comb begin
		memReq = (state == ems_pkg::ST_WRITE) || (state == ems_pkg::ST_VERIFY) ||
			(state == ems_pkg::ST_READ);
		memWrite = (state == ems_pkg::ST_WRITE);
		memAddr = addr;
		memWdata = word;
		busy = (state != ems_pkg::ST_IDLE) && (state != ems_pkg::ST_DONE);
		marginVoltageOn = (state == ems_pkg::ST_APPLY) || (state == ems_pkg::ST_READ) ||
			(state == ems_pkg::ST_UPDATE);
		marginEnable = marginVoltageOn || (state == ems_pkg::ST_ENABLE);
		marginEnableNeg = zeros;
	end

	// voltage never on without the enable
	volt_needs_en_a: assert property (@(posedge core_clk) disable iff (srst)
		$rose(marginVoltageOn) |-> $past(marginEnable))
		else $error("margin voltage without enable");
	// first step of ones search applies half of full scale
	first_step_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == ems_pkg::ST_ENABLE && next_state == ems_pkg::ST_APPLY && !zeros)
		|=> marginVoltage == 16'sh09c4) else $error("first ones step not 2.5 V");
	// search limits start values
	init_lim_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == ems_pkg::ST_ENABLE && wait_cnt == '0) |-> passLim == ems_pkg::LIMIT_ZERO &&
		failLim == (zeros ? ems_pkg::LIMIT_ZEROS : ems_pkg::LIMIT_ONES))
		else $error("wrong starting limits");
	// limit update follows the outcome
	lim_update_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == ems_pkg::ST_UPDATE && mismatch) |=> failLim == $past(marginVoltage))
		else $error("fail limit not updated");
	// exactly nine steps before finishing
	nine_iter_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == ems_pkg::ST_OFF) |-> iter == ems_pkg::ITER_COUNT)
		else $error("iteration count not nine");
	// result is mean of final limits
	result_mean_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == ems_pkg::ST_OFF) |=> done && marginCode == 16'(midSum >>> 1))
		else $error("result not mean of limits");
	// first written word
	first_word_a: assert property (@(posedge core_clk) disable iff (srst)
		(memWrite && addr == '0) |-> memWdata == (invertPattern ? 16'h5555 : 16'haaaa))
		else $error("wrong word at address zero");
	// enable polarity tracks the selection
	en_polarity_a: assert property (@(posedge core_clk) disable iff (srst)
		(!busy && start) |=> marginEnableNeg == $past(selZeros))
		else $error("enable polarity wrong");
	// written words alternate
	alt_word_a: assert property (@(posedge core_clk) disable iff (srst)
		(memWrite && memAck && addr != ems_pkg::LAST_ADDR) |=> memWdata == ~$past(memWdata))
		else $error("pattern not alternating");
	// zeros search opens at half of negative full scale
	first_zero_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == ems_pkg::ST_ENABLE && next_state == ems_pkg::ST_APPLY && zeros)
		|=> marginVoltage == (ems_pkg::LIMIT_ZEROS >>> 1)) else $error("first zeros step wrong");
	// a pass moves only the pass limit
	lim_pass_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == ems_pkg::ST_UPDATE && !mismatch) |=> passLim == $past(marginVoltage) &&
		failLim == $past(failLim)) else $error("pass limit not updated");
	// every later step applies the midpoint of the updated limits
	next_mid_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == ems_pkg::ST_UPDATE && iter != ems_pkg::ITER_COUNT - 4'h1)
		|=> marginVoltage == 16'(midSum >>> 1)) else $error("step not at midpoint");
	// one bad word under margin marks the whole step as failed
	read_fail_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == ems_pkg::ST_READ && memAck && memRdata != word) |=> mismatch)
		else $error("readback mismatch lost");
	// each accepted start rewrites the pattern from address zero
	pattern_rewrite_a: assert property (@(posedge core_clk) disable iff (srst)
		(!busy && start) |=> state == ems_pkg::ST_WRITE && addr == '0)
		else $error("start did not rewrite pattern");
	// margining only ever follows a clean verify pass
	verify_first_a: assert property (@(posedge core_clk) disable iff (srst)
		$rose(marginEnable) |-> $past(state) == ems_pkg::ST_VERIFY)
		else $error("margining without verify");
	// a bad verify ends the run before marginEnable, marginVoltageOn or marginVoltage moves
	pattern_err_a: assert property (@(posedge core_clk) disable iff (srst)
		$rose(patternError) |-> $past(state) == ems_pkg::ST_VERIFY && !marginEnable)
		else $error("pattern error outside verify");
	// the last write hands over to verify at address zero
	all_written_a: assert property (@(posedge core_clk) disable iff (srst)
		(memWrite && memAck && addr == ems_pkg::LAST_ADDR) |=> !memWrite && memReq &&
		addr == '0) else $error("pattern write incomplete");
	// applied voltage stays strictly inside the search window
	volt_window_a: assert property (@(posedge core_clk) disable iff (srst)
		marginVoltageOn |-> (zeros ? (marginVoltage < ems_pkg::LIMIT_ZERO &&
		marginVoltage > ems_pkg::LIMIT_ZEROS) : (marginVoltage > ems_pkg::LIMIT_ZERO &&
		marginVoltage < ems_pkg::LIMIT_ONES))) else $error("voltage outside window");
	// no tenth read pass: every step wears the stored charge
	iter_cap_a: assert property (@(posedge core_clk) disable iff (srst)
		(state == ems_pkg::ST_READ) |-> iter < ems_pkg::ITER_COUNT)
		else $error("too many search steps");
	// done only ever shows while idle
	done_idle_a: assert property (@(posedge core_clk) disable iff (srst)
		done |-> !busy) else $error("done while busy");
endmodule

// ### dv/ems_mem_model.sv
// partner model: 64x16 memory under test with its margining pins
// assumes the sequencer holds memReq and address until it sees memAck
`timescale 1ns/1ns
module ems_mem_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// memory port
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic [5:0] memAddr,
	input wire logic [15:0] memWdata,
	output logic memAck,
	output logic [15:0] memRdata,
	// margining pins
	input wire logic marginEnable,
	input wire logic marginEnableNeg,
	input wire logic marginVoltageOn,
	input wire logic signed [15:0] marginVoltage,
	// pacing and faults set by the bench
	input wire logic slow,
	input wire logic verifyFault,
	input wire logic [5:0] badAddr,
	input wire logic signed [15:0] threshold
);
	logic [15:0] cells [64];
	logic [1:0] gapCnt;
	logic beyond;
	// cell threshold crossed: above it for ones, below it for zeros
	assign beyond = marginEnable && marginVoltageOn && (marginEnableNeg ?
		(marginVoltage < threshold) : (marginVoltage > threshold));
	// one word per ack pulse; idle data toggles so stale values never pass
	always @(posedge core_clk) begin
		if (srst) begin
			memAck <= 1'b0;
			gapCnt <= 2'h0;
			memRdata <= 16'h0000;
		end else if (memAck || !memReq || (slow && gapCnt != 2'h2)) begin
			memAck <= 1'b0;
			memRdata <= ~memRdata;
			gapCnt <= (memReq && !memAck) ? gapCnt + 2'h1 : 2'h0;
		end else begin
			gapCnt <= 2'h0;
			memAck <= 1'b1;
			if (memWrite) begin
				cells[memAddr] <= memWdata;
			end else if ((beyond || (verifyFault && !marginEnable)) && memAddr == badAddr) begin
				memRdata <= ~cells[memAddr];
			end else begin
				memRdata <= cells[memAddr];
			end
		end
	end
endmodule

// ### dv/eeprom_margin_search_tb.sv
// bench for the margin search sequencer against the memory model
// assumes the design is built with a short settle count
`timescale 1ns/1ns
module eeprom_margin_search_tb;
	logic core_clk = 1'b0, srst = 1'b1, start = 1'b0, selZeros = 1'b0, invertPattern = 1'b0;
	logic slow = 1'b0, verifyFault = 1'b0, curZeros = 1'b0, curInv = 1'b0;
	logic [5:0] badAddr = 6'h00;
	logic signed [15:0] threshold = 16'sh0000;
	logic busy, done, patternError, memReq, memWrite, memAck;
	logic marginEnable, marginEnableNeg, marginVoltageOn;
	logic signed [15:0] marginCode, marginVoltage;
	logic [5:0] memAddr;
	logic [15:0] memWdata, memRdata;
	int bad_count = 0, compares = 0, wrCnt = 0, rdCnt = 0, step = 0, cyc = 0;
	int seed = 45389, r, curThr = 0;
	always #4 core_clk = ~core_clk;
	ems_margin_search #(.SETTLE_CYCLES(4)) u_ems_margin_search (.core_clk(core_clk),
		.srst(srst), .start(start), .selZeros(selZeros), .invertPattern(invertPattern),
		.busy(busy), .done(done), .patternError(patternError), .marginCode(marginCode),
		.memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
		.memAck(memAck), .memRdata(memRdata), .marginEnable(marginEnable),
		.marginEnableNeg(marginEnableNeg), .marginVoltageOn(marginVoltageOn),
		.marginVoltage(marginVoltage));
	ems_mem_model u_ems_mem_model (.core_clk(core_clk), .srst(srst), .memReq(memReq),
		.memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
		.memRdata(memRdata), .marginEnable(marginEnable), .marginEnableNeg(marginEnableNeg),
		.marginVoltageOn(marginVoltageOn), .marginVoltage(marginVoltage), .slow(slow),
		.verifyFault(verifyFault), .badAddr(badAddr), .threshold(threshold));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// applied voltage of step k; k of nine gives the reported midpoint
	function automatic int search(input logic z, input int thr, input int k);
		int p, f, v;
		p = int'(ems_pkg::LIMIT_ZERO);
		f = z ? int'(ems_pkg::LIMIT_ZEROS) : int'(ems_pkg::LIMIT_ONES);
		for (int i = 0; i < k; i++) begin
			v = (p + f) >>> 1;
			if (z ? (v >= thr) : (v <= thr)) p = v; else f = v;
		end
		return (p + f) >>> 1;
	endfunction
	function automatic logic [15:0] word(input logic inv, input int n);
		return (inv ? ~ems_pkg::PATTERN_WORD0 : ems_pkg::PATTERN_WORD0) ^
			(n[0] ? 16'hffff : 16'h0000);
	endfunction
	// watch transfers where everything has settled
	always @(negedge core_clk) begin
		if (memReq && memAck && memWrite) begin
			chk({10'h000, memAddr}, 16'(wrCnt));
			chk(memWdata, word(curInv, wrCnt));
			wrCnt++;
		end
		if (memReq && memAck && !memWrite && marginVoltageOn) begin
			chk({14'h0, marginEnable, marginEnableNeg}, {14'h0, 1'b1, curZeros});
			if (memAddr == 6'h00) begin
				chk(marginVoltage, 16'(search(curZeros, curThr, step)));
				step++;
			end
			chk({10'h000, memAddr}, 16'(rdCnt % 64));
			rdCnt++;
		end
	end
	task automatic run(input logic z, input logic inv, input int thr, input logic vf,
		input logic sl, input logic rt);
		int w;
		@(negedge core_clk);
		{selZeros, invertPattern, verifyFault, slow} = {z, inv, vf, sl};
		threshold = 16'(thr);
		badAddr = 6'($random(seed));
		{curZeros, curInv, curThr, wrCnt, rdCnt, step} = {z, inv, thr, 32'd0, 32'd0, 32'd0};
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		chk({14'h0, busy, done}, 16'h0002);
		if (rt) begin
			repeat (30) @(negedge core_clk);
			start = 1'b1;
			@(negedge core_clk);
			start = 1'b0;
		end
		w = 0;
		while (done !== 1'b1 && w < 6000) begin
			@(negedge core_clk);
			w++;
		end
		chk({15'h0, patternError}, {15'h0, vf});
		chk(16'(wrCnt), 16'h0040);
		chk(16'(rdCnt), vf ? 16'h0000 : 16'h0240);
		repeat (3) @(negedge core_clk);
		chk({14'h0, busy, done}, 16'h0001);
		if (!vf) chk(marginCode, 16'(search(z, thr, 9)));
		$display("case zeros=%0d thr=%0d code=%0d", z, thr, marginCode);
	endtask
	task automatic test_done();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// hang guard: the whole sequence needs well under this many cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		repeat (4) @(negedge core_clk);
		srst = 1'b0;
		run(1'b0, 1'b0, 1234, 1'b0, 1'b0, 1'b0);
		// reset in the middle of the write pass must leave everything idle
		@(negedge core_clk);
		wrCnt = 0;
		curInv = invertPattern;
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		repeat (40) @(negedge core_clk);
		srst = 1'b1;
		repeat (2) @(negedge core_clk);
		srst = 1'b0;
		chk({11'h0, busy, done, memReq, marginEnable, marginVoltageOn}, 16'h0000);
		chk(marginCode, 16'h0000);
		run(1'b0, 1'b1, 0, 1'b0, 1'b1, 1'b1);
		run(1'b0, 1'b0, 4999, 1'b0, 1'b0, 1'b0);
		run(1'b1, 1'b0, -5000, 1'b0, 1'b0, 1'b0);
		run(1'b1, 1'b1, -1, 1'b0, 1'b1, 1'b0);
		run(1'b0, 1'b0, 2000, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 3; i++) begin
			r = $random(seed);
			run(r[0], r[1], r[0] ? -int'(r[27:16]) : int'(r[27:16]), 1'b0, r[2], 1'b0);
		end
		test_done();
	end
endmodule
